// [hdl/fsk_reload_pkg.sv]
// shared constants for the fsk tone oscillator reload block
// assumes a 250 MHz ref_clk and apb access to 16-bit registers
package fsk_reload_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int DATA_W = 16;
  localparam int ADDR_W = 12;
  localparam int IDX_W  = 10;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_RELOAD_CTRL = 10'h020;
  localparam logic [IDX_W-1:0] IDX_FSK_CTRL    = 10'h06C;
  localparam logic [IDX_W-1:0] IDX_SPACE_AMP   = 10'h063;
  localparam logic [IDX_W-1:0] IDX_SPACE_FREQ  = 10'h064;
  localparam logic [IDX_W-1:0] IDX_MARK_AMP    = 10'h065;
  localparam logic [IDX_W-1:0] IDX_MARK_FREQ   = 10'h066;
  localparam logic [IDX_W-1:0] IDX_S2M_GAIN    = 10'h067;
  localparam logic [IDX_W-1:0] IDX_M2S_GAIN    = 10'h068;
  localparam logic [IDX_W-1:0] IDX_OSC_AMP     = 10'h070;
  localparam logic [IDX_W-1:0] IDX_OSC_FREQ    = 10'h071;
  localparam logic [IDX_W-1:0] IDX_OSC_TIMER   = 10'h072;
  localparam logic [IDX_W-1:0] IDX_OSC_CTRL    = 10'h073;
  localparam logic [IDX_W-1:0] IDX_STATUS      = 10'h074;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int ENABLE_POS   = 6;
  localparam int RUN_POS      = 0;
  localparam int NEXT_BIT_POS = 1;
  localparam int ST_BIT_POS   = 0;
  localparam int ST_FSK_POS   = 1;
  localparam int ST_CNT_LSB   = 16;
  localparam int GAIN_FRAC    = 14;
  localparam logic [DATA_W-1:0] UNITY_GAIN = 16'h4000;
  localparam logic [DATA_W-1:0] COEF_RESET = 16'h0000;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS    = 4;
  localparam int SAMPLE_PERIOD_NS = 125000;
  localparam int SAMPLE_DIV_CYC   = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b001,
    PH_ARMED = 3'b010,
    PH_DONE  = 3'b100
  } apb_ph_e;

endpackage

// [hdl/gain_if.sv]
// carrier between the reload control and the amplitude scaler
// assumes the scaler answers combinationally
`timescale 1ns/10ps
interface gain_if;
  import fsk_reload_pkg::*;
  logic [DATA_W-1:0] amp;
  logic [DATA_W-1:0] gain;
  logic [DATA_W-1:0] scaled;
  modport ctrl   (output amp, output gain, input scaled);
  modport scaler (input amp, input gain, output scaled);
endinterface

// [hdl/rate_divider.sv]
// divider giving a one-cycle sample tick from ref_clk
// assumes DIV of at least one
`timescale 1ns/10ps
module rate_divider
  import fsk_reload_pkg::*;
#(
  parameter int DIV = SAMPLE_DIV_CYC
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  output logic      tick
);
  localparam int CW = $clog2(DIV + 1);

  if (DIV < 1) begin : g_bad_div
    $error("rate_divider DIV must be at least one");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } div_s;

  div_s s;
  div_s n;

  always_comb begin
    n      = s;
    n.tick = 1'b0;
    if (s.cnt == CW'(DIV - 1)) begin
      n.cnt  = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + CW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;
endmodule

// [hdl/gain_scaler.sv]
// amplitude times gain correction, fixed point, saturating
// assumes gain has GAIN_FRAC fraction bits
`timescale 1ns/10ps
module gain_scaler
  import fsk_reload_pkg::*;
(
  gain_if.scaler gs
);
  logic [2*DATA_W-1:0] prod;
  logic [2*DATA_W-1:0] shifted;

  assign prod    = {{DATA_W{1'b0}}, gs.amp} * {{DATA_W{1'b0}}, gs.gain};
  assign shifted = prod >> GAIN_FRAC;
  // clip instead of wrapping on large gains
  assign gs.scaled = (|shifted[2*DATA_W-1:DATA_W]) ? '1 : shifted[DATA_W-1:0];
endmodule

// [hdl/fsk_tone_oscillator_reload.sv]
// first tone oscillator reload with phase-continuous fsk coefficients
// assumes an apb master on ref_clk and software feeding the next bit
//
// Behaviour
// - fsk mode only while shift keying enable and reload enable are both set
// - in fsk mode a space takes its amplitude from the space amplitude coef
// - in fsk mode a space takes its frequency from the space frequency coef
// - in fsk mode a mark takes its amplitude from the mark amplitude coef
// - in fsk mode a mark takes its frequency from the mark frequency coef
// - on timer expiry in fsk mode load the fsk amplitude, not the normal one
// - on timer expiry in fsk mode load the fsk frequency, not the normal one
// - a space to mark change scales amplitude by the space to mark gain
// - a mark to space change scales amplitude by the mark to space gain
`timescale 1ns/10ps
module fsk_tone_oscillator_reload
  import fsk_reload_pkg::*;
#(
  parameter int SAMPLE_DIV = SAMPLE_DIV_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [DATA_W-1:0]      osc_amplitude,
  output logic [DATA_W-1:0]      osc_frequency,
  output logic [DATA_W-1:0]      osc_gain,
  output logic                   osc_reload,
  output logic                   fsk_active,
  output logic                   current_bit
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    apb_ph_e           ph;
    logic [31:0]       rdata;
    logic              slverr;
    logic [DATA_W-1:0] space_amp;
    logic [DATA_W-1:0] space_freq;
    logic [DATA_W-1:0] mark_amp;
    logic [DATA_W-1:0] mark_freq;
    logic [DATA_W-1:0] s2m_gain;
    logic [DATA_W-1:0] m2s_gain;
    logic [DATA_W-1:0] norm_amp;
    logic [DATA_W-1:0] norm_freq;
    logic [DATA_W-1:0] period;
    logic [DATA_W-1:0] cnt;
    logic              reload_en;
    logic              fsk_en;
    logic              run;
    logic              next_bit;
    logic              cur_bit;
    logic [DATA_W-1:0] out_amp;
    logic [DATA_W-1:0] out_freq;
    logic [DATA_W-1:0] gain;
    logic              reload;
    logic              fsk_act;
  } state_s;

  state_s s;
  state_s n;

  logic             tick;
  logic             expire;
  logic             fsk_mode;
  logic             setup;
  logic             access;
  logic [IDX_W-1:0] idx;
  gain_if           gif ();

  // ****************************************************************
  // parameter check
  // ****************************************************************
  // a divide of one lets expiries touch and merge the reload pulses
  if (SAMPLE_DIV < 2) begin : g_bad_div
    $error("fsk_tone_oscillator_reload SAMPLE_DIV must be at least two");
  end

  // ****************************************************************
  // sample rate and scaler
  // ****************************************************************
  rate_divider #(
    .DIV (SAMPLE_DIV)
  ) u_div (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .tick    (tick)
  );

  gain_scaler u_scale (
    .gs (gif.scaler)
  );

  // ****************************************************************
  // bus decode
  // ****************************************************************
  assign idx    = paddr[ADDR_W-1:2];
  assign setup  = psel & ~penable;
  assign access = psel & penable & (s.ph == PH_ARMED);
  assign pready = access;
  assign pslverr = access & s.slverr;
  assign prdata  = s.rdata;

  function automatic logic known_idx(input logic [IDX_W-1:0] i);
    case (i)
      IDX_RELOAD_CTRL, IDX_FSK_CTRL, IDX_SPACE_AMP, IDX_SPACE_FREQ,
      IDX_MARK_AMP, IDX_MARK_FREQ, IDX_S2M_GAIN, IDX_M2S_GAIN,
      IDX_OSC_AMP, IDX_OSC_FREQ, IDX_OSC_TIMER, IDX_OSC_CTRL,
      IDX_STATUS: known_idx = 1'b1;
      default:    known_idx = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] read_word(input state_s r, input logic [IDX_W-1:0] i);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (i)
      IDX_RELOAD_CTRL: w[ENABLE_POS] = r.reload_en;
      IDX_FSK_CTRL:    w[ENABLE_POS] = r.fsk_en;
      IDX_SPACE_AMP:   w[DATA_W-1:0] = r.space_amp;
      IDX_SPACE_FREQ:  w[DATA_W-1:0] = r.space_freq;
      IDX_MARK_AMP:    w[DATA_W-1:0] = r.mark_amp;
      IDX_MARK_FREQ:   w[DATA_W-1:0] = r.mark_freq;
      IDX_S2M_GAIN:    w[DATA_W-1:0] = r.s2m_gain;
      IDX_M2S_GAIN:    w[DATA_W-1:0] = r.m2s_gain;
      IDX_OSC_AMP:     w[DATA_W-1:0] = r.norm_amp;
      IDX_OSC_FREQ:    w[DATA_W-1:0] = r.norm_freq;
      IDX_OSC_TIMER:   w[DATA_W-1:0] = r.period;
      IDX_OSC_CTRL: begin
        w[RUN_POS]      = r.run;
        w[NEXT_BIT_POS] = r.next_bit;
      end
      IDX_STATUS: begin
        w[ST_BIT_POS]                    = r.cur_bit;
        w[ST_FSK_POS]                    = r.fsk_act;
        w[ST_CNT_LSB+DATA_W-1:ST_CNT_LSB] = r.cnt;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ****************************************************************
  // reload selection
  // ****************************************************************
  assign fsk_mode = s.reload_en & s.fsk_en;
  assign expire   = tick & s.run & (s.cnt == '0);

  always_comb begin
    gif.amp  = s.norm_amp;
    gif.gain = UNITY_GAIN;
    if (fsk_mode) begin
      gif.amp = s.next_bit ? s.mark_amp : s.space_amp;
      if (!s.cur_bit && s.next_bit) begin
        gif.gain = s.s2m_gain;
      end else if (s.cur_bit && !s.next_bit) begin
        gif.gain = s.m2s_gain;
      end
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n        = s;
    n.reload = 1'b0;
    n.fsk_act = fsk_mode;

    case (s.ph)
      PH_IDLE:  n.ph = setup ? PH_ARMED : PH_IDLE;
      PH_ARMED: n.ph = access ? PH_DONE : PH_ARMED;
      PH_DONE:  n.ph = setup ? PH_ARMED : PH_IDLE;
      default:  n.ph = PH_IDLE;
    endcase

    if (setup) begin
      n.rdata  = pwrite ? 32'h0000_0000 : read_word(s, idx);
      n.slverr = ~known_idx(idx) | (pwrite & (idx == IDX_STATUS));
    end

    if (access && pwrite && !s.slverr) begin
      case (idx)
        IDX_RELOAD_CTRL: n.reload_en  = pwdata[ENABLE_POS];
        IDX_FSK_CTRL:    n.fsk_en     = pwdata[ENABLE_POS];
        IDX_SPACE_AMP:   n.space_amp  = pwdata[DATA_W-1:0];
        IDX_SPACE_FREQ:  n.space_freq = pwdata[DATA_W-1:0];
        IDX_MARK_AMP:    n.mark_amp   = pwdata[DATA_W-1:0];
        IDX_MARK_FREQ:   n.mark_freq  = pwdata[DATA_W-1:0];
        IDX_S2M_GAIN:    n.s2m_gain   = pwdata[DATA_W-1:0];
        IDX_M2S_GAIN:    n.m2s_gain   = pwdata[DATA_W-1:0];
        IDX_OSC_AMP:     n.norm_amp   = pwdata[DATA_W-1:0];
        IDX_OSC_FREQ:    n.norm_freq  = pwdata[DATA_W-1:0];
        IDX_OSC_TIMER:   n.period     = pwdata[DATA_W-1:0];
        IDX_OSC_CTRL: begin
          n.run      = pwdata[RUN_POS];
          n.next_bit = pwdata[NEXT_BIT_POS];
        end
        default: n.run = s.run;
      endcase
    end

    // active timer counts sample ticks, restarts at the period
    if (!s.run) begin
      n.cnt = s.period;
    end else if (expire) begin
      n.cnt    = s.period;
      n.reload = 1'b1;
      n.out_amp = gif.scaled;
      n.gain    = gif.gain;
      if (fsk_mode) begin
        n.out_freq = s.next_bit ? s.mark_freq : s.space_freq;
        n.cur_bit  = s.next_bit;
      end else begin
        n.out_freq = s.norm_freq;
      end
    end else if (tick) begin
      n.cnt = s.cnt - DATA_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s            <= '0;
      s.ph         <= PH_IDLE;
      s.space_amp  <= COEF_RESET;
      s.space_freq <= COEF_RESET;
      s.mark_amp   <= COEF_RESET;
      s.mark_freq  <= COEF_RESET;
      s.s2m_gain   <= UNITY_GAIN;
      s.m2s_gain   <= UNITY_GAIN;
      s.gain       <= UNITY_GAIN;
    end else begin
      s <= n;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign osc_amplitude = s.out_amp;
  assign osc_frequency = s.out_freq;
  assign osc_gain      = s.gain;
  assign osc_reload    = s.reload;
  assign fsk_active    = s.fsk_act;
  assign current_bit   = s.cur_bit;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  fsk_mode_gate_a: assert property (
    fsk_active |-> $past(s.reload_en) && $past(s.fsk_en))
    else $error("fsk active without both enables");

  space_amp_load_a: assert property (
    expire && fsk_mode && !s.next_bit && !s.cur_bit
      |=> 32'(osc_amplitude) == (32'($past(s.space_amp)) * 32'(UNITY_GAIN)) >> GAIN_FRAC)
    else $error("space amplitude not loaded");

  space_freq_load_a: assert property (
    expire && fsk_mode && !s.next_bit |=> osc_frequency == $past(s.space_freq))
    else $error("space frequency not loaded");

  mark_amp_load_a: assert property (
    expire && fsk_mode && s.next_bit && s.cur_bit
      |=> osc_gain == UNITY_GAIN && osc_amplitude == $past(s.mark_amp))
    else $error("mark amplitude not loaded");

  mark_freq_load_a: assert property (
    expire && fsk_mode && s.next_bit |=> osc_frequency == $past(s.mark_freq)
      && current_bit)
    else $error("mark frequency not loaded");

  reload_pulse_a: assert property (
    expire |=> osc_reload ##1 !osc_reload)
    else $error("reload pulse wrong");

  fsk_freq_only_a: assert property (
    expire && fsk_mode && (s.mark_freq != s.norm_freq) && s.next_bit
      |=> osc_frequency != $past(s.norm_freq))
    else $error("normal frequency used in fsk mode");

  s2m_gain_a: assert property (
    expire && fsk_mode && !s.cur_bit && s.next_bit |=> osc_gain == $past(s.s2m_gain))
    else $error("space to mark gain missing");

  m2s_gain_a: assert property (
    expire && fsk_mode && s.cur_bit && !s.next_bit |=> osc_gain == $past(s.m2s_gain))
    else $error("mark to space gain missing");

  normal_reload_a: assert property (
    expire && !fsk_mode |=> osc_frequency == $past(s.norm_freq)
      && osc_amplitude == $past(s.norm_amp) && osc_gain == UNITY_GAIN
      && current_bit == $past(s.cur_bit))
    else $error("normal reload wrong");

  apb_answer_a: assert property (
    setup ##1 psel && penable |-> pready)
    else $error("apb access not answered");

  reload_cause_a: assert property (
    osc_reload |-> $past(expire))
    else $error("reload pulse without expiry");

  out_hold_a: assert property (
    !osc_reload |-> $stable(osc_amplitude) && $stable(osc_frequency)
      && $stable(osc_gain))
    else $error("oscillator values moved between reloads");

  bit_hold_a: assert property (
    !osc_reload |-> $stable(current_bit))
    else $error("current bit moved between reloads");

  same_bit_unity_a: assert property (
    expire && fsk_mode && (s.cur_bit == s.next_bit) |=> osc_gain == UNITY_GAIN)
    else $error("gain applied without a bit change");

  idle_no_reload_a: assert property (
    !s.run |=> !osc_reload)
    else $error("reload while timer stopped");

  apb_refuse_a: assert property (
    access && (!known_idx(idx) || (pwrite && (idx == IDX_STATUS))) |-> pslverr)
    else $error("refused access not flagged");

  err_data_zero_a: assert property (
    pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");

  write_drop_a: assert property (
    access && pwrite && pslverr |=> $stable(s.reload_en) && $stable(s.fsk_en)
      && $stable(s.run) && $stable(s.period))
    else $error("refused write changed a register");

endmodule

// [bench/tb.sv]
// self-checking bench for the fsk tone oscillator reload block
// assumes zero-wait apb and SAMPLE_DIV shortened to 4 clocks
`timescale 1ns/10ps
module tb
  import fsk_reload_pkg::*;
;
  logic              ref_clk;
  logic              arst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [DATA_W-1:0] osc_amplitude;
  logic [DATA_W-1:0] osc_frequency;
  logic [DATA_W-1:0] osc_gain;
  logic              osc_reload;
  logic              fsk_active;
  logic              current_bit;
  int                num_errors;
  int                num_checks;
  logic [IDX_W-1:0]  coef_idx [6];
  logic [15:0]       coef_val [6];

  // ****************************************************************
  // design, clock, reset
  // ****************************************************************
  fsk_tone_oscillator_reload #(.SAMPLE_DIV(4)) u_dut (
    .ref_clk       (ref_clk),
    .arst_n        (arst_n),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .osc_amplitude (osc_amplitude),
    .osc_frequency (osc_frequency),
    .osc_gain      (osc_gain),
    .osc_reload    (osc_reload),
    .fsk_active    (fsk_active),
    .current_bit   (current_bit)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // compare and access tasks
  // ****************************************************************
  task automatic fail(input string msg);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  task automatic chk1(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) fail(msg);
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", msg, got, exp));
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", msg, got, exp));
  endtask

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail("no pready");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] wd, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, wd, rd, err);
    chk1(err, exp_err, "write error response");
  endtask

  task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 32'h0000_0000, rd, err);
    chk32(rd, exp, "read data");
    chk1(err, exp_err, "read error response");
  endtask

  // saturating q2.14 product
  function automatic logic [15:0] scaled(input logic [15:0] amp, input logic [15:0] gain);
    logic [31:0] p;
    p = ({16'h0000, amp} * {16'h0000, gain}) >> GAIN_FRAC;
    return (p > 32'h0000_FFFF) ? 16'hFFFF : p[15:0];
  endfunction

  task automatic reload_chk(input logic [15:0] amp, input logic [15:0] freq,
                            input logic [15:0] gain, input logic bit_v);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (osc_reload !== 1'b1 && n < 200);
    if (n >= 200) fail("no reload");
    chk16(osc_amplitude, scaled(amp, gain), "amplitude");
    chk16(osc_frequency, freq, "frequency");
    chk16(osc_gain, gain, "gain");
    chk1(current_bit, bit_v, "current bit");
  endtask

  task automatic results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    logic [31:0] rd;
    logic        err;
    num_errors = 0;
    num_checks = 0;
    arst_n  = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    coef_idx = '{IDX_SPACE_AMP, IDX_SPACE_FREQ, IDX_MARK_AMP, IDX_MARK_FREQ,
                 IDX_S2M_GAIN, IDX_M2S_GAIN};
    coef_val = '{16'hC000, 16'h1111, 16'h1234, 16'h2222, 16'h2000, 16'h6000};
    repeat (16) @(posedge ref_clk);
    chk16(osc_gain, UNITY_GAIN, "gain in reset");
    chk1(fsk_active, 1'b0, "fsk idle in reset");
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd_chk(coef_idx[i], {16'h0000, (i < 4) ? COEF_RESET : UNITY_GAIN}, 1'b0);
    end
    for (int i = 0; i < 6; i++) begin
      wr(coef_idx[i], {16'h0000, coef_val[i]}, 1'b0);
    end
    for (int i = 0; i < 6; i++) begin
      rd_chk(coef_idx[i], {16'h0000, coef_val[i]}, 1'b0);
    end
    rd_chk(10'h3FF, 32'h0000_0000, 1'b1);
    wr(IDX_STATUS, 32'h0000_0003, 1'b1);
    wr(IDX_OSC_AMP, 32'h0000_0777, 1'b0);
    wr(IDX_OSC_FREQ, 32'h0000_0999, 1'b0);
    wr(IDX_OSC_TIMER, 32'h0000_0003, 1'b0);
    wr(IDX_OSC_CTRL, 32'h0000_0003, 1'b0);
    reload_chk(16'h0777, 16'h0999, UNITY_GAIN, 1'b0);
    wr(IDX_RELOAD_CTRL, 32'h0000_0040, 1'b0);
    reload_chk(16'h0777, 16'h0999, UNITY_GAIN, 1'b0);
    reload_chk(16'h0777, 16'h0999, UNITY_GAIN, 1'b0);
    chk1(fsk_active, 1'b0, "fsk with one enable");
    wr(IDX_OSC_CTRL, 32'h0000_0001, 1'b0);
    wr(IDX_FSK_CTRL, 32'h0000_0040, 1'b0);
    reload_chk(16'hC000, 16'h1111, UNITY_GAIN, 1'b0);
    chk1(fsk_active, 1'b1, "fsk with both enables");
    apb(1'b0, IDX_STATUS, 32'h0000_0000, rd, err);
    chk1(rd[ST_FSK_POS], 1'b1, "status fsk");
    wr(IDX_OSC_CTRL, 32'h0000_0003, 1'b0);
    reload_chk(16'h1234, 16'h2222, 16'h2000, 1'b1);
    reload_chk(16'h1234, 16'h2222, UNITY_GAIN, 1'b1);
    wr(IDX_OSC_CTRL, 32'h0000_0001, 1'b0);
    reload_chk(16'hC000, 16'h1111, 16'h6000, 1'b0);
    wr(IDX_RELOAD_CTRL, 32'h0000_0000, 1'b0);
    wr(IDX_OSC_CTRL, 32'h0000_0003, 1'b0);
    reload_chk(16'h0777, 16'h0999, UNITY_GAIN, 1'b0);
    reload_chk(16'h0777, 16'h0999, UNITY_GAIN, 1'b0);
    results();
  end

  // ****************************************************************
  // watchdog
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail("watchdog expired");
    results();
  end
endmodule
